//--- rtl/slalu_pkg.sv
/*
  package for the subtract and logic alu slice: opcodes, flag layout, cycle counts.
  assumes a surrounding core that supplies operands and writes results back.
*/
`default_nettype none
package slalu_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SUB_BORROW_REGS,
    OP_SUB_BORROW_IMM,
    OP_SUB_IMM_WORD,
    OP_AND_WITH_IMM,
    OP_OR_WITH_IMM
  } slalu_op_t;

  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  localparam int CYCLES_BYTE_OP = 1;
  localparam int CYCLES_WORD_OP = 2;

  typedef struct packed {
    slalu_op_t  op;
    logic [7:0] dest;
    logic [7:0] dest_hi;
    logic [7:0] operand;
  } slalu_req_t;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] res_hi;
    logic [5:0] flags;
  } slalu_rsp_t;
endpackage
`default_nettype wire

//--- rtl/slalu_core.sv
/*
  subtract and logic alu slice of an 8-bit core.
  assumes requests arrive synchronous to clk_i, one at a time, held until done.
*/
`default_nettype none
module slalu_core (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 start_i,
  input  wire slalu_pkg::slalu_req_t req_i,
  input  wire logic [5:0]           flags_i,
  output logic                      done_o,
  output slalu_pkg::slalu_rsp_t     rsp_o
);
  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // byte operations
  // ****************************************
  logic       cin;
  logic [8:0] diff;
  logic [4:0] half;
  logic [7:0] d;
  logic [7:0] k;
  logic [7:0] land;
  logic [7:0] lor;
  assign d    = req_i.dest;
  assign k    = req_i.operand;
  assign cin  = flags_i[slalu_pkg::FLAG_C];

  // ****************************************
  // borrow chain, one stage per bit
  // ****************************************
  logic [8:0] brw;
  logic [7:0] dbit;
  assign brw[0] = cin;
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign dbit[i]  = d[i] ^ k[i] ^ brw[i];
    assign brw[i+1] = (~d[i] & k[i]) | (~(d[i] ^ k[i]) & brw[i]);
  end
  assign diff = {brw[8], dbit};
  assign half = {brw[4], dbit[3:0]};
  assign land = d & k;
  assign lor  = d | k;

  logic [5:0] sub_flags;
  always_comb begin
    sub_flags = flags_i;
    sub_flags[slalu_pkg::FLAG_C] = diff[8];
    // zero carries over from the previous flag for a borrow chain
    sub_flags[slalu_pkg::FLAG_Z] = (diff[7:0] == 8'h00) & flags_i[slalu_pkg::FLAG_Z];
    sub_flags[slalu_pkg::FLAG_N] = diff[7];
    sub_flags[slalu_pkg::FLAG_V] = (d[7] ^ k[7]) & (d[7] ^ diff[7]);
    sub_flags[slalu_pkg::FLAG_H] = half[4];
  end

  logic [5:0] and_flags;
  logic [5:0] or_flags;
  always_comb begin
    and_flags = flags_i;
    and_flags[slalu_pkg::FLAG_Z] = (land == 8'h00);
    and_flags[slalu_pkg::FLAG_N] = land[7];
    and_flags[slalu_pkg::FLAG_V] = 1'b0;
    or_flags = flags_i;
    or_flags[slalu_pkg::FLAG_Z] = (lor == 8'h00);
    or_flags[slalu_pkg::FLAG_N] = lor[7];
    or_flags[slalu_pkg::FLAG_V] = 1'b0;
  end

  // ****************************************
  // word operation
  // ****************************************
  logic [15:0] word_in;
  logic [15:0] word_res;
  logic [5:0]  word_flags;
  assign word_in  = {req_i.dest_hi, req_i.dest};
  assign word_res = word_in - {8'h00, k};
  always_comb begin
    word_flags = flags_i;
    word_flags[slalu_pkg::FLAG_C] = word_res[15] & ~word_in[15];
    word_flags[slalu_pkg::FLAG_Z] = (word_res == 16'h0000);
    word_flags[slalu_pkg::FLAG_N] = word_res[15];
    word_flags[slalu_pkg::FLAG_V] = word_in[15] & ~word_res[15];
    word_flags[slalu_pkg::FLAG_S] = word_res[15] ^ (word_in[15] & ~word_res[15]);
  end

  // ****************************************
  // sequencing
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WORD} slalu_state_t;
  slalu_state_t          state_q;
  slalu_state_t          state_d;
  logic                  done_q;
  logic                  done_d;
  slalu_pkg::slalu_rsp_t rsp_q;
  slalu_pkg::slalu_rsp_t rsp_d;

  always_comb begin
    state_d = state_q;
    done_d  = 1'b0;
    rsp_d   = rsp_q;
    case (state_q)
      ST_IDLE: begin
        if (start_i) begin
          rsp_d.res_hi = req_i.dest_hi;
          rsp_d.flags  = flags_i;
          done_d       = 1'b1;
          case (req_i.op)
            slalu_pkg::OP_SUB_BORROW_REGS: begin
              rsp_d.res   = diff[7:0];
              rsp_d.flags = sub_flags;
            end
            slalu_pkg::OP_SUB_BORROW_IMM: begin
              rsp_d.res   = diff[7:0];
              rsp_d.flags = sub_flags;
            end
            slalu_pkg::OP_SUB_IMM_WORD: begin
              rsp_d.res    = word_res[7:0];
              rsp_d.res_hi = word_res[15:8];
              rsp_d.flags  = word_flags;
              done_d       = 1'b0;
              state_d      = ST_WORD;
            end
            slalu_pkg::OP_AND_WITH_IMM: begin
              rsp_d.res   = land;
              rsp_d.flags = and_flags;
            end
            slalu_pkg::OP_OR_WITH_IMM: begin
              rsp_d.res   = lor;
              rsp_d.flags = or_flags;
            end
            default: begin
              rsp_d.res = d;
            end
          endcase
        end
      end
      ST_WORD: begin
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      done_q  <= 1'b0;
      rsp_q   <= '{res: 8'h00, res_hi: 8'h00, flags: slalu_pkg::FLAGS_RESET};
    end else begin
      state_q <= state_d;
      done_q  <= done_d;
      rsp_q   <= rsp_d;
    end
  end

  assign done_o = done_q;
  assign rsp_o  = rsp_q;
endmodule
`default_nettype wire

//--- dv/slalu_assertions.sv
/* port checker for slalu_core; assumes the bind below */
`default_nettype none
module slalu_chk (
  input wire logic                  clk_i,
  input wire logic                  arst_n_i,
  input wire logic                  start_i,
  input wire slalu_pkg::slalu_req_t req_i,
  input wire logic [5:0]            flags_i,
  input wire logic                  done_o,
  input wire slalu_pkg::slalu_rsp_t rsp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic [2:0] op = req_i.op;
  property p_sbr; start_i && op == 1 |=> done_o &&
    rsp_o.res == $past(req_i.dest - req_i.operand - flags_i[0]); endproperty
  a_sbr: assert property (p_sbr) else $error("sbr");
  property p_sbi; start_i && op == 2 |=> done_o &&
    rsp_o.flags[0] == $past({1'b0, req_i.dest} < {1'b0, req_i.operand} + flags_i[0]); endproperty
  a_sbi: assert property (p_sbi) else $error("sbi");
  property p_word; start_i && op == 3 |=> !done_o ##1 done_o; endproperty
  a_word: assert property (p_word) else $error("word");
  property p_and; start_i && op == 4 |=> done_o && !rsp_o.flags[3] &&
    rsp_o.res == $past(req_i.dest & req_i.operand); endproperty
  a_and: assert property (p_and) else $error("and");
  property p_or; start_i && op == 5 |=> done_o && !rsp_o.flags[3] &&
    rsp_o.res == $past(req_i.dest | req_i.operand); endproperty
  a_or: assert property (p_or) else $error("or");
  property p_keep; start_i && op > 3 |=> rsp_o.flags[0] == $past(flags_i[0]); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  c_word: cover property (start_i && op == 3);
  c_brw: cover property (start_i && op == 1 && flags_i[0]);
  c_or: cover property (start_i && op == 5);
endmodule
bind slalu_core slalu_chk i_slalu_chk (.*);
`default_nettype wire

//--- dv/tb.sv
/* random-op bench for slalu_core; assumes the bound checker */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_i = 0, arst_n_i = 0, start_i = 0, done_o;
  logic [5:0]            flags_i = 0;
  logic [8:0]            d;
  logic [16:0]           s;
  logic [21:0]           q[$];
  logic [31:0]           x = 32'h74e5;
  int                    n_mismatch = 0, tests_run = 0, cyc = 0;
  slalu_pkg::slalu_req_t req_i = 0;
  slalu_pkg::slalu_rsp_t rsp_o;
  always #20 clk_i = ~clk_i;
  slalu_core i_slalu_core (.*);
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [21:0] ex, got);
    tests_run++;
    if (got !== ex) n_mismatch++;
    if (got !== ex) $display("[ERR] rsp exp %h got %h", ex, got);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (done_o === 1'b1) chk(q.size() ? q.pop_front() : 'x,
      {rsp_o.res_hi, rsp_o.res, rsp_o.flags});
    if (cyc > 1000) n_mismatch++;
    if (cyc > 1000) end_sim();
  end
  task automatic run(input logic [2:0] op);
    logic [5:0] f;
    logic [4:0] h;
    @(negedge clk_i);
    start_i = 1;
    req_i.op = slalu_pkg::slalu_op_t'(op);
    {req_i.dest_hi, req_i.dest, req_i.operand, flags_i} = 30'(rnd());
    d = {1'b0, req_i.dest} - req_i.operand - flags_i[0];
    h = {1'b0, req_i.dest[3:0]} - req_i.operand[3:0] - flags_i[0];
    s = {1'b0, req_i.dest_hi, req_i.dest} - req_i.operand;
    f = flags_i;
    case (op)
      0: q.push_back({req_i.dest_hi, req_i.dest, f});
      3: begin
        f[slalu_pkg::FLAG_C] = s[16];
        f[slalu_pkg::FLAG_Z] = (s[15:0] == 16'h0000);
        f[slalu_pkg::FLAG_N] = s[15];
        f[slalu_pkg::FLAG_V] = req_i.dest_hi[7] & ~s[15];
        f[slalu_pkg::FLAG_S] = s[15] ^ (req_i.dest_hi[7] & ~s[15]);
        q.push_back({s[15:0], f});
      end
      4: begin
        f[slalu_pkg::FLAG_Z] = ((req_i.dest & req_i.operand) == 8'h00);
        f[slalu_pkg::FLAG_N] = req_i.dest[7] & req_i.operand[7];
        f[slalu_pkg::FLAG_V] = 1'b0;
        q.push_back({req_i.dest_hi, req_i.dest & req_i.operand, f});
      end
      5: begin
        f[slalu_pkg::FLAG_Z] = ((req_i.dest | req_i.operand) == 8'h00);
        f[slalu_pkg::FLAG_N] = req_i.dest[7] | req_i.operand[7];
        f[slalu_pkg::FLAG_V] = 1'b0;
        q.push_back({req_i.dest_hi, req_i.dest | req_i.operand, f});
      end
      default: begin
        f[slalu_pkg::FLAG_C] = d[8];
        f[slalu_pkg::FLAG_Z] = (d[7:0] == 8'h00) & flags_i[slalu_pkg::FLAG_Z];
        f[slalu_pkg::FLAG_N] = d[7];
        f[slalu_pkg::FLAG_V] = (req_i.dest[7] ^ req_i.operand[7]) & (req_i.dest[7] ^ d[7]);
        f[slalu_pkg::FLAG_H] = h[4];
        q.push_back({req_i.dest_hi, d[7:0], f});
      end
    endcase
    @(negedge clk_i);
    start_i = 0;
    if (op == 3) @(negedge clk_i);
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    arst_n_i = 1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 200; i++) run(3'(rnd() % 6));
    repeat (3) @(posedge clk_i);
    $display("random op test done");
    end_sim();
  end
endmodule
`default_nettype wire
